/* spi_control_and_clock_rate.sv */
// Purpose: control/status flags, select-line handling and serial clock rate of one serial port
// Assumes: shift datapath supplies transfer events as one-cycle pulses, synchronous to clk
// Notes: registers on the special-function bus; reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

`include "spi_ctl_defines.svh"

// What this block does
// - set done flag at transfer end, sticky
// - done flag raises port interrupt request
// - data write while busy sets collision flag
// - select low in master four-wire sets fault
// - slave last bit over unread data: overrun
// - mode 00: select pin unused, three-wire
// - mode 01 (reset): select pin is input
// - mode 1x: drive select with low bit
// - data write clears transmit-empty bit
// - buffer moved to shift sets transmit-empty
// - master clock is core/(2*(divider+1))
// - master_enable chooses master or slave
// - master data write starts a transfer
module spi_control_and_clock_rate
	import spi_ctl_pkg::*;
#(
	parameter logic [7:0] CONTROL_ADDR = `PORT0_CONTROL_STATUS_ADDR,
	parameter logic [7:0] DIVIDER_ADDR = `PORT0_CLOCK_DIVIDER_ADDR
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire sfr_req_s   sfr_req,
	output logic     [7:0]  sfr_rdata,
	input  wire logic       master_enable,
	input  wire logic       data_write,
	input  wire logic       transfer_busy,
	input  wire logic       transfer_end,
	input  wire logic       last_bit_in,
	input  wire logic       rx_unread,
	input  wire logic       tx_to_shift,
	input  wire logic       slave_select_pin_in,
	output logic            slave_select_pin_out,
	output logic            slave_select_pin_oe_n,
	output logic            start_transfer,
	output logic            serial_clock,
	output logic            serial_clock_edge,
	output logic            irq_request
);

	control_status_s ctl;
	control_status_s next_ctl;
	logic [7:0]      clock_divider_value;
	logic [7:0]      next_clock_divider_value;
	logic [7:0]      next_sfr_rdata;
	logic            next_irq_request;
	logic            next_start_transfer;
	logic            next_select_out;
	logic            next_select_oe_n;
	logic            ctl_wr;
	logic            div_wr;
	logic            fault_cond;
	logic            sck_run;

	// register address decode
	always_comb
	begin
		ctl_wr = 1'b0;
		div_wr = 1'b0;
		if (sfr_req.wr && sfr_req.addr == CONTROL_ADDR)
			ctl_wr = 1'b1;
		else if (sfr_req.wr && sfr_req.addr == DIVIDER_ADDR)
			div_wr = 1'b1;
	end

	// master collision: select pulled low by another master
	assign fault_cond = ctl.port_enable && master_enable && ctl.select_line_mode == SEL_FOUR_WIRE
		&& !slave_select_pin_in;

	// flags, mode, enable and divider; hardware set wins over software clear
	always_comb
	begin
		next_ctl                 = ctl;
		next_clock_divider_value = clock_divider_value;
		if (ctl_wr)
		begin
			next_ctl                       = control_status_s'(sfr_req.wdata);
			next_ctl.transmit_buffer_empty = ctl.transmit_buffer_empty; // read-only bit
		end
		if (div_wr)
			next_clock_divider_value = sfr_req.wdata;
		if (data_write)
			next_ctl.transmit_buffer_empty = 1'b0;
		else if (tx_to_shift)
			next_ctl.transmit_buffer_empty = 1'b1;
		if (ctl.port_enable && transfer_end)
			next_ctl.transfer_done_flag = 1'b1;
		if (ctl.port_enable && data_write && transfer_busy)
			next_ctl.write_collision_flag = 1'b1;
		if (fault_cond)
			next_ctl.mode_fault_flag = 1'b1;
		if (ctl.port_enable && !master_enable && last_bit_in && rx_unread)
			next_ctl.receive_overrun_flag = 1'b1;
	end

	// interrupt, transfer start, select pin and read data
	always_comb
	begin
		next_irq_request    = next_ctl.transfer_done_flag || next_ctl.write_collision_flag
			|| next_ctl.mode_fault_flag || next_ctl.receive_overrun_flag;
		next_start_transfer = ctl.port_enable && master_enable && data_write && !transfer_busy;
		next_select_out     = 1'b1;
		next_select_oe_n    = 1'b1;
		case (ctl.select_line_mode)
			SEL_THREE_WIRE: next_select_oe_n = 1'b1;
			SEL_FOUR_WIRE:  next_select_oe_n = 1'b1;
			default:
			begin
				next_select_oe_n = !ctl.port_enable;
				next_select_out  = ctl.select_line_mode[0];
			end
		endcase
		next_sfr_rdata = 8'h00;
		if (sfr_req.rd && sfr_req.addr == CONTROL_ADDR)
			next_sfr_rdata = ctl;
		else if (sfr_req.rd && sfr_req.addr == DIVIDER_ADDR)
			next_sfr_rdata = clock_divider_value;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctl                   <= control_status_s'(`CONTROL_STATUS_RESET);
			clock_divider_value   <= `CLOCK_DIVIDER_RESET;
			irq_request           <= 1'b0;
			start_transfer        <= 1'b0;
			slave_select_pin_out  <= 1'b1;
			slave_select_pin_oe_n <= 1'b1;
			sfr_rdata             <= 8'h00;
		end
		else
		begin
			ctl                   <= next_ctl;
			clock_divider_value   <= next_clock_divider_value;
			irq_request           <= next_irq_request;
			start_transfer        <= next_start_transfer;
			slave_select_pin_out  <= next_select_out;
			slave_select_pin_oe_n <= next_select_oe_n;
			sfr_rdata             <= next_sfr_rdata;
		end
	end

	// divider runs only for an enabled master transfer
	assign sck_run = ctl.port_enable && master_enable && transfer_busy;

	spi_sck_divider #(
		.WIDTH (8)
	) u_sck_divider (
		.clk       (clk),
		.rst       (rst),
		.run       (sck_run),
		.divider   (clock_divider_value),
		.sck_level (serial_clock),
		.sck_edge  (serial_clock_edge)
	);

	chk_done_sticky: assert property (@(posedge clk) disable iff (rst)
		(ctl.transfer_done_flag && !(ctl_wr && !sfr_req.wdata[`BIT_TRANSFER_DONE])) |=> ctl.transfer_done_flag)
		else $error("done flag dropped without a software clear");

	chk_done_set: assert property (@(posedge clk) disable iff (rst)
		(ctl.port_enable && transfer_end) |=> ctl.transfer_done_flag)
		else $error("done flag not set at transfer end");

	chk_irq_done: assert property (@(posedge clk) disable iff (rst)
		$rose(ctl.transfer_done_flag) |-> irq_request)
		else $error("interrupt not requested with done flag");

	chk_collision_set: assert property (@(posedge clk) disable iff (rst)
		(ctl.port_enable && data_write && transfer_busy) |=> (ctl.write_collision_flag && irq_request))
		else $error("write collision not flagged");

	chk_fault_set: assert property (@(posedge clk) disable iff (rst)
		(ctl.port_enable && master_enable && ctl.select_line_mode == SEL_FOUR_WIRE && !slave_select_pin_in)
			|=> (ctl.mode_fault_flag && irq_request))
		else $error("mode fault not flagged");

	chk_overrun_slave: assert property (@(posedge clk) disable iff (rst)
		(master_enable && !ctl.receive_overrun_flag && !(ctl_wr && sfr_req.wdata[`BIT_RECEIVE_OVERRUN]))
			|=> !ctl.receive_overrun_flag)
		else $error("overrun flagged in master mode");

	chk_overrun_set: assert property (@(posedge clk) disable iff (rst)
		(ctl.port_enable && !master_enable && last_bit_in && rx_unread)
			|=> (ctl.receive_overrun_flag && irq_request))
		else $error("receive overrun not flagged in slave mode");

	chk_select_input: assert property (@(posedge clk) disable iff (rst)
		(ctl.select_line_mode inside {SEL_THREE_WIRE, SEL_FOUR_WIRE}) |=> slave_select_pin_oe_n)
		else $error("select pin driven in input or three-wire mode");

	chk_select_drive: assert property (@(posedge clk) disable iff (rst)
		(ctl.port_enable && ctl.select_line_mode[1]) |=>
			(!slave_select_pin_oe_n && slave_select_pin_out == $past(ctl.select_line_mode[0])))
		else $error("select pin not driven with mode low bit");

	chk_tx_empty: assert property (@(posedge clk) disable iff (rst)
		(data_write |=> !ctl.transmit_buffer_empty) and
		((tx_to_shift && !data_write) |=> ctl.transmit_buffer_empty))
		else $error("transmit-empty bit wrong after write or load");

	chk_start_master: assert property (@(posedge clk) disable iff (rst)
		start_transfer |-> ($past(ctl.port_enable) && $past(master_enable) && $past(data_write)))
		else $error("transfer started without an enabled master write");

endmodule : spi_control_and_clock_rate

`default_nettype wire

/* spi_ctl_defines.svh */
// Purpose: offsets, field positions, reset values of the serial port control registers
// Assumes: 8-bit special-function register space
// Notes: one port instance uses one address pair, chosen by module parameters
`ifndef SPI_CTL_DEFINES_SVH
`define SPI_CTL_DEFINES_SVH

// register addresses, port 0 and port 1
`define PORT0_CONTROL_STATUS_ADDR 8'hf8
`define PORT0_CLOCK_DIVIDER_ADDR  8'ha2
`define PORT1_CONTROL_STATUS_ADDR 8'hb0
`define PORT1_CLOCK_DIVIDER_ADDR  8'h85

// control/status field positions
`define BIT_TRANSFER_DONE   7
`define BIT_WRITE_COLLISION 6
`define BIT_MODE_FAULT      5
`define BIT_RECEIVE_OVERRUN 4
`define BIT_TX_EMPTY        1
`define BIT_PORT_ENABLE     0

// reset values
`define CONTROL_STATUS_RESET 8'h06
`define CLOCK_DIVIDER_RESET  8'h00

`endif

/* spi_ctl_pkg.sv */
// Purpose: types shared by the serial port control block
// Assumes: nothing beyond the defines header
// Notes: struct layout follows the control/status byte, bit 7 first
package spi_ctl_pkg;

	// select-line handling modes
	typedef enum logic [1:0] {
		SEL_THREE_WIRE = 2'b00,
		SEL_FOUR_WIRE  = 2'b01,
		SEL_DRIVE_LOW  = 2'b10,
		SEL_DRIVE_HIGH = 2'b11
	} select_line_mode_e;

	// control/status byte
	typedef struct packed {
		logic              transfer_done_flag;
		logic              write_collision_flag;
		logic              mode_fault_flag;
		logic              receive_overrun_flag;
		select_line_mode_e select_line_mode;
		logic              transmit_buffer_empty;
		logic              port_enable;
	} control_status_s;

	// special-function register access
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_s;

endpackage : spi_ctl_pkg

/* spi_sck_divider.sv */
// Purpose: serial clock generator dividing the core clock
// Assumes: run held high for the whole master transfer
// Notes: half period is divider+1 core clocks; idles low when not running
`timescale 1ns/1ps
`default_nettype none

module spi_sck_divider #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] divider,
	output logic                  sck_level,
	output logic                  sck_edge
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_sck_level;
	logic             next_sck_edge;

	// count divider+1 cycles per half period, then toggle
	always_comb
	begin
		next_count     = count;
		next_sck_level = sck_level;
		next_sck_edge  = 1'b0;
		if (!run)
		begin
			next_count     = '0;
			next_sck_level = 1'b0;
		end
		else if (count >= divider)
		begin
			next_count     = '0;
			next_sck_level = !sck_level;
			next_sck_edge  = 1'b1;
		end
		else
		begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count     <= '0;
			sck_level <= 1'b0;
			sck_edge  <= 1'b0;
		end
		else
		begin
			count     <= next_count;
			sck_level <= next_sck_level;
			sck_edge  <= next_sck_edge;
		end
	end

	// helper: cycles the level has held since the last toggle
	// cleared on the toggling edge itself, so a full half period reads divider
	logic [WIDTH:0] hold_len;
	always_ff @(posedge clk)
	begin
		if (rst || !run || next_sck_edge)
			hold_len <= '0;
		else
			hold_len <= hold_len + 1'b1;
	end

	// a level held through a steady run lasts divider+1 cycles
	chk_half_period: assert property (@(posedge clk) disable iff (rst)
		(run && $past(run) && sck_edge && !$past(sck_edge) && $stable(divider))
			|-> ($past(hold_len) == {1'b0, divider}))
		else $error("serial clock half period differs from divider+1");

	chk_idle_low: assert property (@(posedge clk) disable iff (rst)
		!run |=> !sck_level)
		else $error("serial clock toggles while not running");

endmodule : spi_sck_divider

`default_nettype wire

/* spi_far_party.sv */
// Purpose: far-side party on the shared select line
// Assumes: select line carries a pull-up
// Notes: pulls the line low only while asked to, else releases it
`timescale 1ns/1ps
`default_nettype none

module spi_far_party (
	input  wire logic assert_select,
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	output logic      select_wire
);
	// wired level: pull-up, device drive, far-side low drive
	always_comb
	begin
		select_wire = 1'b1;
		if (!dev_oe_n)
			select_wire = dev_out;
		if (assert_select)
			select_wire = 1'b0;
	end
endmodule : spi_far_party

`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench of the serial port control block
// Assumes: inputs change 1 ns after the rising edge
// Notes: reset values first, then register table, flag, select and clock cases
`timescale 1ns/1ps
`default_nettype none

`include "spi_ctl_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
	import spi_ctl_pkg::*;
	typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_s;
	logic       clk = 0, rst = 1, mst = 0, dwr = 0, busy = 0, tend = 0;
	logic       lbit = 0, unread = 0, tx2sh = 0, pull = 0;
	logic [7:0] rdata, got;
	logic       sel_out, sel_oe_n, start, sck, sck_edge, irq, sel_wire;
	sfr_req_s   req = '0;
	int         bad_count = 0, samples_checked = 0, n;
	row_s       rows[6] = '{{8'ha2, 8'h5a, 8'h5a}, {8'ha2, 8'hff, 8'hff}, {8'hf8, 8'h0c, 8'h0e},
		{8'hf8, 8'h00, 8'h02}, {8'h55, 8'h77, 8'h00}, {8'ha2, 8'h00, 8'h00}};

	spi_control_and_clock_rate dut (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
		.master_enable(mst), .data_write(dwr), .transfer_busy(busy), .transfer_end(tend),
		.last_bit_in(lbit), .rx_unread(unread), .tx_to_shift(tx2sh), .slave_select_pin_in(sel_wire),
		.slave_select_pin_out(sel_out), .slave_select_pin_oe_n(sel_oe_n), .start_transfer(start),
		.serial_clock(sck), .serial_clock_edge(sck_edge), .irq_request(irq));
	spi_far_party far (.assert_select(pull), .dev_out(sel_out), .dev_oe_n(sel_oe_n), .select_wire(sel_wire));

	// core clock, 50 ns period
	always #25 clk = ~clk;

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a; req.wdata = d; req.wr = 1'b1;
		tick();
		req.wr = 1'b0;
		tick(); // idle edge between transfers
	endtask : wr

	task automatic rd(input logic [7:0] a);
		req.addr = a; req.rd = 1'b1;
		tick();
		req.rd = 1'b0;
		got = rdata;
		tick(); // idle edge between transfers
	endtask : rd

	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// watchdog, far beyond the roughly 120 cycles of the run
	initial
	begin
		#(50 * 5000);
		bad_count++;
		test_done();
	end

	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		#1 rst = 0;
		`CHK(sel_oe_n, 1'b1)
		`CHK(irq, 1'b0)
		rd(8'hf8); `CHK(got, 8'h06)
		rd(8'ha2); `CHK(got, 8'h00)
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a); `CHK(got, rows[i].e)
		end
		$display("register table test done");
		// done flag is sticky until written to zero
		wr(8'hf8, 8'h05);
		tend = 1; tick(); tend = 0;
		repeat (3) tick();
		`CHK(irq, 1'b1)
		rd(8'hf8); `CHK(got, 8'h87)
		wr(8'hf8, 8'h05);
		`CHK(irq, 1'b0)
		$display("done flag test done");
		// data write while busy, then buffer to shift register
		busy = 1; dwr = 1; tick(); dwr = 0;
		`CHK(start, 1'b0)
		rd(8'hf8); `CHK(got, 8'h45)
		tx2sh = 1; tick(); tx2sh = 0;
		rd(8'hf8); `CHK(got, 8'h47)
		busy = 0; wr(8'hf8, 8'h05);
		$display("collision test done");
		// master start pulse, then far side pulls select low
		mst = 1; dwr = 1; tick(); dwr = 0;
		`CHK(start, 1'b1)
		tick(); `CHK(start, 1'b0)
		rd(8'hf8); `CHK(got, 8'h05)
		pull = 1; tick(); pull = 0;
		rd(8'hf8); `CHK(got, 8'h25)
		`CHK(irq, 1'b1)
		wr(8'hf8, 8'h05);
		$display("mode fault test done");
		// slave overrun
		mst = 0; unread = 1; lbit = 1; tick(); lbit = 0;
		rd(8'hf8); `CHK(got, 8'h15)
		// disabled port sets no flag
		wr(8'hf8, 8'h04);
		tend = 1; lbit = 1; tick(); tend = 0; lbit = 0;
		rd(8'hf8); `CHK(got, 8'h04)
		unread = 0;
		$display("overrun and disable test done");
		// every select-line mode
		for (int m = 0; m < 4; m++)
		begin
			wr(8'hf8, 8'(m * 4 + 1));
			tick();
			`CHK(sel_oe_n, logic'(m < 2))
			`CHK(sel_wire, (m < 2) ? 1'b1 : logic'(m % 2))
		end
		$display("select mode test done");
		// serial clock half period is divider+1 core clocks
		mst = 1; wr(8'hf8, 8'h05);
		foreach (rows[i])
		begin
			if (i > 2)
				break;
			wr(8'ha2, 8'(i * i + i / 2 * 2));
			busy = 1;
			n = 0;
			while (sck_edge !== 1'b1 && n < 300)
				begin tick(); n++; end
			n = 0;
			do begin tick(); n++; end while (sck_edge !== 1'b1 && n < 300);
			`CHK(n, i * i + i / 2 * 2 + 1)
			busy = 0; tick(); tick();
			`CHK(sck, 1'b0)
		end
		$display("serial clock test done");
		// reset in mid-run restores the register values
		tend = 1; tick(); tend = 0;
		`CHK(irq, 1'b1)
		rst = 1; tick(); tick(); rst = 0;
		`CHK(irq, 1'b0)
		rd(8'hf8); `CHK(got, 8'h06)
		rd(8'ha2); `CHK(got, 8'h00)
		$display("mid-run reset test done");
		test_done();
	end
endmodule : tb_top

`default_nettype wire
